// File: gpio_port.v
// six-line general-purpose port with comparator, recovery input and interrupts
//
// Operation
// - six lines, each software-selectable as input or output
// - each line's direction held and applied independently
// - line five as output only pulls low, never drives high
// - each alternate function active only while its special-function bit is set
// - line0 recovery, line1 timer out, line2 interrupt_input_three, line3 ref, line4 comp/interrupt_input_one/interrupt_input_four
// - full reset leaves output value register unchanged
// - full reset clears all direction bits, all lines inputs
// - full reset clears input value register to zero; pin samples reach it from the third clock edge after release
// - full reset clears special-function register to zero
// - stop recovery and watchdog timeout leave output value, direction and special-function registers untouched
// - comparator enabled by special-function bits three and four
// - comparator on: input bit4 is comparator result, bit3 reference sample
// - comparator on: line-four interrupts sourced from comparator result
// - comparator high when signal above reference, low when below
// - comparator works in halt; its interrupt wakes from halt
// - comparator disabled and powered down during stop mode
// - low on line0 for minimum width triggers recovery, restart at 0020h
//
// The address map and the address-and-strobe port were chosen for this implementation.
`include "gpio_port_defines.vh"
module gpio_port #(
  parameter LINES = 6,
  parameter RECOVERY_CYCLES = `RECOVERY_CYCLES
) (
  input wire SYS_CLK, // system clock, 125 MHz
  input wire SYS_RST, // full reset, async, active high
  input wire [3:0] ADDR, // register address
  input wire [7:0] WDATA, // write data
  input wire WR, // write strobe
  input wire RD, // read strobe
  output reg [7:0] RDATA, // read data, cycle after strobe
  input wire [LINES-1:0] PIN_IN, // pin levels
  output reg [LINES-1:0] PIN_OUT, // pin drive levels
  output reg [LINES-1:0] PIN_OE, // pin drive enables
  input wire COMP_ABOVE, // analog front end: signal above reference
  output reg COMP_POWER, // comparator powered
  input wire TIMER_ZERO_OUT, // timer zero output level
  input wire WATCHDOG_TIMEOUT, // watchdog timeout event
  output reg INTERRUPT_INPUT_ONE, // interrupt request one, one-cycle pulse per event
  output reg INTERRUPT_INPUT_THREE, // interrupt request three, one-cycle pulse per event
  output reg INTERRUPT_INPUT_FOUR, // interrupt request four, one-cycle pulse per event
  output reg STOP_RECOVERY, // recovery pulse to core
  output reg [15:0] RESTART_ADDR, // restart vector for core
  output reg HALT_WAKE, // wake pulse out of halt
  output reg IRQ // level interrupt output
);
  reg [LINES-1:0] out_value;
  reg [LINES-1:0] direction;
  reg [LINES-1:0] in_value;
  reg [LINES-1:0] special;
  reg [4:0] irq_status;
  reg [4:0] irq_mask;
  reg halt_mode;
  reg stop_mode;
  reg sample_pending;
  reg [LINES-1:0] next_in;
  reg [LINES-1:0] next_oe;
  reg [LINES-1:0] next_out;
  reg [4:0] events;
  reg comp_q;
  reg src_one_four_q;
  reg line_two_q;
  wire [LINES-1:0] pins_sync;
  wire comp_sync;
  wire recovery_hit;
  wire comp_on;
  wire src_one_four;

  line_sync #(.WIDTH(LINES)) u_pins (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .d(PIN_IN),
    .q(pins_sync)
  );

  line_sync #(.WIDTH(1)) u_comp (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .d(COMP_ABOVE),
    .q(comp_sync)
  );

  // recovery sensing armed only while stopped, line0 input and function enabled
  low_pulse_detect #(.CYCLES(RECOVERY_CYCLES)) u_recovery (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .arm(stop_mode & ~direction[0] & special[`SF_RECOVERY]),
    .level(pins_sync[0]),
    .hit(recovery_hit)
  );

  // comparator needs both function bits and is off while stopped
  assign comp_on = special[`SF_COMP_REF] & special[`SF_COMP_SIG] & ~stop_mode;
  assign src_one_four = comp_on ? comp_sync : pins_sync[4];

  always @* begin
    next_in = pins_sync;
    if (comp_on) begin
      next_in[4] = comp_sync;
      next_in[3] = pins_sync[3];
    end
  end

  // drive each line from its own direction bit
  always @* begin
    next_oe = direction;
    next_out = out_value;
    if (special[`SF_TIMER_OUT]) begin
      next_out[1] = TIMER_ZERO_OUT;
    end
    // line five drives only low: enable follows the low level
    next_oe[5] = direction[5] & ~out_value[5];
    next_out[5] = 1'b0;
  end

  always @* begin
    events = 5'h00;
    events[`IRQ_ONE] = special[`SF_IRQ_ONE_FOUR] & src_one_four_q & ~src_one_four;
    events[`IRQ_FOUR] = special[`SF_IRQ_ONE_FOUR] & ~src_one_four_q & src_one_four;
    events[`IRQ_THREE] = special[`SF_IRQ_THREE] & line_two_q & ~pins_sync[2];
    events[`IRQ_COMP] = comp_on & (comp_q ^ comp_sync);
    events[`IRQ_RECOVERY] = recovery_hit;
  end

  // output value register has no reset: it keeps its contents over a full reset
  always @(posedge SYS_CLK) begin
    if (WR && ADDR == `ADDR_OUT_VALUE) begin
      out_value <= WDATA[LINES-1:0];
    end
  end

  // watchdog events never touch these registers; a recovery event clears only stop_mode
  always @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      direction <= `DIRECTION_RESET;
      special <= `SPECIAL_RESET;
      sample_pending <= 1'b1;
      in_value <= 6'h00;
      irq_mask <= 5'h00;
      halt_mode <= 1'b0;
      stop_mode <= 1'b0;
    end else begin
      sample_pending <= 1'b0;
      // first cycle after release loads the synchroniser output, which still holds its reset zeros
      if (sample_pending) begin
        in_value <= pins_sync;
      end else begin
        in_value <= next_in;
      end
      if (WR && ADDR == `ADDR_DIRECTION) begin
        direction <= WDATA[LINES-1:0];
      end
      if (WR && ADDR == `ADDR_SPECIAL) begin
        special <= WDATA[LINES-1:0];
      end
      if (WR && ADDR == `ADDR_IRQ_MASK) begin
        irq_mask <= WDATA[4:0];
      end
      if (WR && ADDR == `ADDR_MODE) begin
        halt_mode <= WDATA[`MODE_HALT];
        stop_mode <= WDATA[`MODE_STOP];
      end else begin
        if (recovery_hit) begin
          stop_mode <= 1'b0;
        end
        if (HALT_WAKE) begin
          halt_mode <= 1'b0;
        end
      end
    end
  end

  always @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_status <= 5'h00;
      comp_q <= 1'b0;
      src_one_four_q <= 1'b0;
      line_two_q <= 1'b0;
      RDATA <= 8'h00;
      PIN_OUT <= 6'h00;
      PIN_OE <= 6'h00;
      COMP_POWER <= 1'b0;
      INTERRUPT_INPUT_ONE <= 1'b0;
      INTERRUPT_INPUT_THREE <= 1'b0;
      INTERRUPT_INPUT_FOUR <= 1'b0;
      STOP_RECOVERY <= 1'b0;
      RESTART_ADDR <= 16'h0000;
      HALT_WAKE <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      comp_q <= comp_sync;
      src_one_four_q <= src_one_four;
      line_two_q <= pins_sync[2];
      // a read clears the status; an event in the same cycle still sets
      if (RD && ADDR == `ADDR_IRQ_STATUS) begin
        irq_status <= events;
      end else begin
        irq_status <= irq_status | events;
      end
      PIN_OUT <= next_out;
      PIN_OE <= next_oe;
      COMP_POWER <= comp_on;
      INTERRUPT_INPUT_ONE <= events[`IRQ_ONE];
      INTERRUPT_INPUT_THREE <= events[`IRQ_THREE];
      INTERRUPT_INPUT_FOUR <= events[`IRQ_FOUR];
      STOP_RECOVERY <= recovery_hit;
      if (recovery_hit) begin
        RESTART_ADDR <= `RESTART_VECTOR;
      end
      HALT_WAKE <= halt_mode & events[`IRQ_COMP] & irq_mask[`IRQ_COMP];
      IRQ <= |((irq_status | events) & irq_mask);
      RDATA <= 8'h00;
      if (RD) begin
        case (ADDR)
          `ADDR_OUT_VALUE: RDATA <= {2'h0, out_value};
          `ADDR_DIRECTION: RDATA <= {2'h0, direction};
          `ADDR_IN_VALUE: RDATA <= {2'h0, in_value};
          `ADDR_SPECIAL: RDATA <= {2'h0, special};
          `ADDR_IRQ_STATUS: RDATA <= {3'h0, irq_status};
          `ADDR_IRQ_MASK: RDATA <= {3'h0, irq_mask};
          `ADDR_MODE: RDATA <= {6'h00, stop_mode, halt_mode};
          default: RDATA <= 8'h00;
        endcase
      end
    end
  end
endmodule // gpio_port

// File: gpio_port_defines.vh
// offsets, field positions, reset values and timing counts of the six-line port
`ifndef GPIO_PORT_DEFINES_VH
`define GPIO_PORT_DEFINES_VH
`define ADDR_OUT_VALUE 4'h0
`define ADDR_DIRECTION 4'h1
`define ADDR_IN_VALUE 4'h2
`define ADDR_SPECIAL 4'h3
`define ADDR_IRQ_STATUS 4'h4
`define ADDR_IRQ_MASK 4'h5
`define ADDR_MODE 4'h6
`define DIRECTION_RESET 6'h00
`define SPECIAL_RESET 6'h00
`define SF_RECOVERY 0
`define SF_TIMER_OUT 1
`define SF_IRQ_THREE 2
`define SF_COMP_REF 3
`define SF_COMP_SIG 4
`define SF_IRQ_ONE_FOUR 5
`define MODE_HALT 0
`define MODE_STOP 1
`define IRQ_ONE 0
`define IRQ_THREE 1
`define IRQ_FOUR 2
`define IRQ_COMP 3
`define IRQ_RECOVERY 4
`define RECOVERY_MIN_NS 1000
`define CLK_PERIOD_NS 8
`define RECOVERY_CYCLES ((`RECOVERY_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESTART_VECTOR 16'h0020
`endif

// File: line_sync.v
// two-flop synchroniser, one per line via a generate loop
module line_sync #(
  parameter WIDTH = 6
) (
  input wire clk, // system clock
  input wire rst, // async reset, active high
  input wire [WIDTH-1:0] d, // asynchronous levels
  output wire [WIDTH-1:0] q // synchronised levels
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg first;
      reg second;
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          first <= 1'b0;
          second <= 1'b0;
        end else begin
          first <= d[i];
          second <= first;
        end
      end
      assign q[i] = second;
    end
  endgenerate
endmodule // line_sync

// File: low_pulse_detect.v
// detects a low level held for a minimum number of cycles
module low_pulse_detect #(
  parameter CYCLES = 125
) (
  input wire clk, // system clock
  input wire rst, // async reset, active high
  input wire arm, // detection armed
  input wire level, // synchronised line level
  output reg hit // one-cycle pulse when width reached
);
  reg [15:0] count;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 16'h0000;
      hit <= 1'b0;
    end else begin
      hit <= 1'b0;
      if (!arm || level) begin
        count <= 16'h0000;
      end else if (count == CYCLES[15:0] - 16'h0001) begin
        hit <= 1'b1;
        count <= 16'h0000;
      end else begin
        count <= count + 16'h0001;
      end
    end
  end
endmodule // low_pulse_detect

// File: board_model.sv
// board circuitry hanging on the six port lines
module board_model (
  input wire [5:0] pin_out, // port drive levels
  input wire [5:0] pin_oe, // port drive enables
  input wire [5:0] level, // level the board puts on an undriven line
  output wire [5:0] pin_in // resolved pin levels
);
  timeunit 1ns;
  timeprecision 1ns;
  // a driven line follows the port, an undriven one the board
  assign pin_in[4:0] = (pin_oe[4:0] & pin_out[4:0]) | (~pin_oe[4:0] & level[4:0]);
  // line five can only sink, so whenever it is released it follows the board level
  assign pin_in[5] = pin_oe[5] ? 1'b0 : level[5];
endmodule // board_model

// File: gpio_port_checker.sv
// assertions on the six-line port outputs
module gpio_port_checker (
  input wire SYS_CLK, // clock
  input wire SYS_RST, // reset
  input wire WR, // write strobe
  input wire RD, // read strobe
  input wire [7:0] RDATA, // read data
  input wire [5:0] PIN_OUT, // drive levels
  input wire [5:0] PIN_OE, // drive enables
  input wire COMP_POWER, // comparator powered
  input wire WATCHDOG_TIMEOUT, // watchdog event
  input wire STOP_RECOVERY, // recovery pulse
  input wire [15:0] RESTART_ADDR, // restart vector
  input wire HALT_WAKE // halt wake pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  property p_line5_low; PIN_OUT[5] == 1'b0; endproperty
  property p_reset_inputs; disable iff (1'b0) SYS_RST |-> PIN_OE == 6'h00 && !COMP_POWER; endproperty
  property p_wdt_keep; WATCHDOG_TIMEOUT && !WR && !$past(WR) |=> $stable(PIN_OE); endproperty
  property p_restart; STOP_RECOVERY |=> RESTART_ADDR == 16'h0020; endproperty
  property p_recovery_pulse; STOP_RECOVERY |=> !STOP_RECOVERY; endproperty
  property p_stop_power; STOP_RECOVERY |-> !$past(COMP_POWER); endproperty
  property p_wake_power; HALT_WAKE |-> $past(COMP_POWER, 2) || $past(COMP_POWER); endproperty
  property p_rd_idle; !RD |=> RDATA == 8'h00; endproperty
  a_line5_low: assert property (p_line5_low)
    else $error("line five driven high");
  a_reset_inputs: assert property (p_reset_inputs)
    else $error("lines or comparator active in reset");
  a_wdt_keep: assert property (p_wdt_keep)
    else $error("watchdog event changed directions");
  a_restart: assert property (p_restart)
    else $error("restart vector wrong after recovery");
  a_recovery_pulse: assert property (p_recovery_pulse)
    else $error("recovery pulse too long");
  a_stop_power: assert property (p_stop_power)
    else $error("comparator powered in stop");
  a_wake_power: assert property (p_wake_power)
    else $error("halt wake without comparator");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read cycle");
  c_recovery: cover property (STOP_RECOVERY);
  c_wake: cover property (HALT_WAKE);
  c_wdt: cover property (WATCHDOG_TIMEOUT);
endmodule // gpio_port_checker
bind gpio_port gpio_port_checker i_checker (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .WR(WR),
  .RD(RD), .RDATA(RDATA), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .COMP_POWER(COMP_POWER),
  .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT), .STOP_RECOVERY(STOP_RECOVERY),
  .RESTART_ADDR(RESTART_ADDR), .HALT_WAKE(HALT_WAKE));

// File: gpio_port_bench.sv
// self-checking bench of the six-line port
module gpio_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, wr = 0, rd = 0, comp = 0, tmr = 0, wdt = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, v;
  logic [5:0] level = 6'h3f;
  wire [7:0] rdata;
  wire [5:0] pin_in, pin_out, pin_oe;
  wire [15:0] restart;
  wire cpow, i1, i3, i4, srec, wake, irq;
  int error_cnt = 0, tests_run = 0, cyc = 0, n;
  initial forever #4 clk = ~clk;
  gpio_port #(.RECOVERY_CYCLES(4)) i_dut (.SYS_CLK(clk), .SYS_RST(rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE(pin_oe), .COMP_ABOVE(comp), .COMP_POWER(cpow), .TIMER_ZERO_OUT(tmr),
    .WATCHDOG_TIMEOUT(wdt), .INTERRUPT_INPUT_ONE(i1), .INTERRUPT_INPUT_THREE(i3),
    .INTERRUPT_INPUT_FOUR(i4), .STOP_RECOVERY(srec), .RESTART_ADDR(restart),
    .HALT_WAKE(wake), .IRQ(irq));
  board_model i_board (.pin_out(pin_out), .pin_oe(pin_oe), .level(level), .pin_in(pin_in));
  task chk(string nm, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr_reg(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_chk(string nm, logic [3:0] a, logic [7:0] m, logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, {8'h00, e}, {8'h00, rdata & m});
  endtask
  task wait_n(int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      stop_test();
    end
  end
  task t_reset;
    rd_chk("direction", 4'h1, 8'hff, 8'h00);
    rd_chk("special", 4'h3, 8'hff, 8'h00);
    rd_chk("input", 4'h2, 8'hff, 8'h3f);
    rd_chk("unmapped", 4'hf, 8'hff, 8'h00);
  endtask
  task t_lines;
    wr_reg(4'h0, 8'h0a);
    wr_reg(4'h1, 8'h2b);
    wait_n(2);
    chk("drive enables", 16'h002b, 16'(pin_oe));
    chk("drive levels", 16'h000a, 16'(pin_out & pin_oe));
    wr_reg(4'h0, 8'h2a);
    wait_n(4);
    rd_chk("input mix", 4'h2, 8'hff, 8'h3e);
    wr_reg(4'h3, 8'h02);
    wait_n(2);
    chk("timer line", 16'h0000, 16'(pin_out[1]));
    wr_reg(4'h3, 8'h00);
    wait_n(2);
    chk("plain line one", 16'h0001, 16'(pin_out[1]));
  endtask
  task t_full_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wr_reg(4'h1, 8'h0f);
    wait_n(2);
    chk("kept outputs", 16'h000a, 16'(pin_out & 6'h0f));
  endtask
  task t_comp;
    wr_reg(4'h1, 8'h00);
    wr_reg(4'h3, 8'h18);
    wait_n(4);
    chk("comp power", 16'h0001, 16'(cpow));
    rd_chk("comp low", 4'h2, 8'h18, 8'h08);
    comp <= 1'b1;
    level <= 6'h2f;
    wait_n(4);
    rd_chk("comp high", 4'h2, 8'h18, 8'h18);
    wr_reg(4'h3, 8'h10);
    wait_n(4);
    rd_chk("comp off", 4'h2, 8'h18, 8'h08);
    level <= 6'h3f;
  endtask
  task t_irq;
    wr_reg(4'h3, 8'h38);
    wr_reg(4'h5, 8'h00);
    rd_chk("clear status", 4'h4, 8'h00, 8'h00);
    comp <= 1'b0;
    wait_n(4);
    chk("masked irq", 16'h0000, 16'(irq));
    wr_reg(4'h5, 8'h01);
    wait_n(2);
    chk("unmasked irq", 16'h0001, 16'(irq));
    rd_chk("status one", 4'h4, 8'h01, 8'h01);
    wait_n(2);
    chk("cleared irq", 16'h0000, 16'(irq));
    wr_reg(4'h5, 8'h08);
    wr_reg(4'h6, 8'h01);
    comp <= 1'b1;
    n = 0;
    while (wake !== 1'b1 && n < 10) begin
      wait_n(1);
      n++;
    end
    chk("halt wake", 16'h0001, 16'(wake));
    rd_chk("status four", 4'h4, 8'h04, 8'h04);
    wr_reg(4'h6, 8'h00);
  endtask
  task t_recovery;
    wr_reg(4'h3, 8'h19);
    wr_reg(4'h6, 8'h02);
    wait_n(2);
    chk("stop power", 16'h0000, 16'(cpow));
    wdt <= 1'b1;
    wait_n(1);
    wdt <= 1'b0;
    level <= 6'h3e;
    n = 0;
    while (srec !== 1'b1 && n < 20) begin
      wait_n(1);
      n++;
    end
    chk("recovery", 16'h0001, 16'(srec));
    wait_n(1);
    chk("restart", 16'h0020, restart);
    rd_chk("special kept", 4'h3, 8'hff, 8'h19);
    rd_chk("direction kept", 4'h1, 8'hff, 8'h00);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wait_n(4);
    t_reset();
    t_lines();
    t_full_reset();
    t_comp();
    t_irq();
    t_recovery();
    stop_test();
  end
endmodule // gpio_port_bench
